// ### asnf_consts.vh
// constants for the asynchronous serial port: register indices, field
// positions, reset values and timing counts. definitions only.
`ifndef ASNF_CONSTS_VH
`define ASNF_CONSTS_VH

// printed register offsets are not word aligned: they are indices,
// byte address on the bus is four times the index
`define ASNF_IDX_CTRL_ONE 12'hF98
`define ASNF_IDX_FLAGS 12'hF98
`define ASNF_IDX_CTRL_TWO 12'hF99
`define ASNF_IDX_RX_HOLD 12'hF9A
`define ASNF_IDX_TX_HOLD 12'hF9A

// serial_control_one fields
`define ASNF_C1_TX_EN 7
`define ASNF_C1_RX_EN 6
`define ASNF_C1_TX_STOP 5
`define ASNF_C1_EVEN 4
`define ASNF_C1_PAR_INS 3
`define ASNF_C1_BAUD_HI 2
`define ASNF_C1_BAUD_LO 0
`define ASNF_C1_RESET 8'h00

// serial_control_two fields
`define ASNF_C2_FILT_HI 2
`define ASNF_C2_FILT_LO 1
`define ASNF_C2_RX_STOP 0
`define ASNF_C2_RESET 3'h0

// serial_flags fields
`define ASNF_F_PAR_FAULT 7
`define ASNF_F_FRAME_FAULT 6
`define ASNF_F_OVERRUN 5
`define ASNF_F_RXFULL 4
`define ASNF_F_TXDONE 3
`define ASNF_F_TXEMPTY 2
`define ASNF_FLAGS_RESET 8'h0C
`define ASNF_HOLD_RESET 8'h00

// baud dividers of the system clock, one sub_bit_tick per division
`define ASNF_DIV_000 9'd13
`define ASNF_DIV_001 9'd26
`define ASNF_DIV_010 9'd52
`define ASNF_DIV_011 9'd104
`define ASNF_DIV_100 9'd208
`define ASNF_DIV_101 9'd416
`define ASNF_DIV_111 9'd96
`define ASNF_BAUD_EXT 3'b110

// sub_bit_tick positions inside one bit
`define ASNF_SUB_LAST 4'd15
`define ASNF_SUB_S7 4'd7
`define ASNF_SUB_S8 4'd8
`define ASNF_SUB_S9 4'd9

// noise filter: one less than the system clocks a level must hold before it is taken
`define ASNF_FILT_T1 7'd31
`define ASNF_FILT_T2 7'd63
`define ASNF_FILT_T3 7'd127

`endif

// ### asnf_rx_filter.v
// digital noise filter for the synchronised receive line.
// assumes its input is already in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "asnf_consts.vh"

module asnf_rx_filter (
	input wire sys_clk,
	input wire sys_rst,
	input wire line_in,
	input wire [1:0] filt_sel,
	output reg line_out
);

reg [6:0] run_reg;
reg [6:0] limit;

always @* begin
	case (filt_sel)
		2'b01: limit = `ASNF_FILT_T1;
		2'b10: limit = `ASNF_FILT_T2;
		default: limit = `ASNF_FILT_T3;
	endcase
end

// a new level is taken once it has held limit+1 clocks: shorter pulses
// are dropped, which keeps well inside the always-accepted lengths
always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		run_reg <= 7'h00;
		line_out <= 1'b1;
	end else if (filt_sel == 2'b00) begin
		run_reg <= 7'h00;
		line_out <= line_in;
	end else if (line_in == line_out) begin
		run_reg <= 7'h00;
	end else if (run_reg == limit) begin
		run_reg <= 7'h00;
		line_out <= line_in;
	end else begin
		run_reg <= run_reg + 7'h01;
	end
end

endmodule
`default_nettype wire

// ### asnf_uart.v
// asynchronous serial port with receive noise filter, AHB-Lite slave.
// assumes a single AHB-Lite master; rx_line is asynchronous, the
// external timer tick is a one-cycle pulse on sys_clk.
//
// Summary of operation
// - frame is start, data, parity, stop bits
// - tx stop length picks one or two
// - rx stop length picks one or two
// - parity only when enabled; even picks type
// - baud select picks divider or timer tick
// - timer tick rate over sixteen sets baud
// - idle receiver samples until low start
// - majority of samples seven, eight, nine
// - filter select rejects short pulses
// - longer pulses always pass the filter
// - buffer write clears empty, starts frame
// - frame start sets empty, raises tx irq
// - tx line high while idle or disabled
// - status read must precede buffer write
// - stop bits done loads buffer, rx irq
// - overrun discards new byte, buffer kept
// - disable waits for current frame end
// - after framing error software re-receives
// - held byte not sent on enable
// - baud and parity shared by both
// - reset flags read 0000 11
// - flags clear on status then buffer read
// - stop bit zero sets framing fault
// - overrun sets, blocks reception until cleared
// - tx done sets when idle empty
`timescale 1ns/1ps
`default_nettype none
`include "asnf_consts.vh"

module asnf_uart (
	input wire sys_clk,
	input wire sys_rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	input wire ext_timer_tick,
	input wire rx_line,
	output reg tx_line,
	output reg tx_irq,
	output reg rx_irq
);

localparam TX_IDLE = 3'd0;
localparam TX_START = 3'd1;
localparam TX_DATA = 3'd2;
localparam TX_PAR = 3'd3;
localparam TX_STOP = 3'd4;

localparam RX_IDLE = 3'd0;
localparam RX_START = 3'd1;
localparam RX_DATA = 3'd2;
localparam RX_PAR = 3'd3;
localparam RX_STOP = 3'd4;

// registers
reg [7:0] ctrl_one_reg;
reg [2:0] ctrl_two_reg;
reg [7:0] rx_hold_reg;
reg [7:0] tx_hold_reg;
reg par_fault_reg, frame_fault_reg, overrun_reg, rxfull_reg, txdone_reg, txempty_reg;
reg [3:0] seen_reg;
reg tx_armed_reg;
reg tx_pend_reg;

// bus
reg wr_pend_reg;
reg [11:0] wr_idx_reg;
wire addr_phase = hsel & hready & htrans[1];
wire [11:0] acc_idx = haddr[13:2];
wire rd_flags = addr_phase & ~hwrite & (acc_idx == `ASNF_IDX_FLAGS);
wire rd_rxbuf = addr_phase & ~hwrite & (acc_idx == `ASNF_IDX_RX_HOLD);
wire wr_c1 = wr_pend_reg & (wr_idx_reg == `ASNF_IDX_CTRL_ONE);
wire wr_c2 = wr_pend_reg & (wr_idx_reg == `ASNF_IDX_CTRL_TWO);
wire wr_txbuf = wr_pend_reg & (wr_idx_reg == `ASNF_IDX_TX_HOLD);

wire tx_en = ctrl_one_reg[`ASNF_C1_TX_EN];
wire rx_en = ctrl_one_reg[`ASNF_C1_RX_EN];
wire par_ins = ctrl_one_reg[`ASNF_C1_PAR_INS];
wire par_even = ctrl_one_reg[`ASNF_C1_EVEN];
wire [2:0] baud_select = ctrl_one_reg[`ASNF_C1_BAUD_HI:`ASNF_C1_BAUD_LO];
wire [7:0] flags_view = {par_fault_reg, frame_fault_reg, overrun_reg, rxfull_reg,
	txdone_reg, txempty_reg, 2'b00};

reg [7:0] rd_mux;
always @* begin
	if (acc_idx == `ASNF_IDX_FLAGS) begin
		rd_mux = flags_view;
	end else if (acc_idx == `ASNF_IDX_RX_HOLD) begin
		rd_mux = rx_hold_reg;
	end else begin
		rd_mux = 8'h00;
	end
end

// zero-wait slave: read data is latched in the address phase so it
// stands from a flop during the data phase
always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		hreadyout <= 1'b0;
		hresp <= 1'b0;
		hrdata <= 32'h0000_0000;
		wr_pend_reg <= 1'b0;
		wr_idx_reg <= 12'h000;
		ctrl_one_reg <= `ASNF_C1_RESET;
		ctrl_two_reg <= `ASNF_C2_RESET;
	end else begin
		hreadyout <= 1'b1;
		wr_pend_reg <= addr_phase & hwrite;
		if (addr_phase) begin
			wr_idx_reg <= acc_idx;
		end
		if (addr_phase & ~hwrite) begin
			hrdata <= {24'h00_0000, rd_mux};
		end
		if (wr_c1) begin
			ctrl_one_reg <= hwdata[7:0];
		end
		if (wr_c2) begin
			ctrl_two_reg <= hwdata[2:0];
		end
	end
end

// baud timing: one divider serves both directions
reg [8:0] div_cnt_reg;
reg sub_tick;
reg [8:0] div_val;
always @* begin
	case (baud_select)
		3'b000: div_val = `ASNF_DIV_000;
		3'b001: div_val = `ASNF_DIV_001;
		3'b010: div_val = `ASNF_DIV_010;
		3'b011: div_val = `ASNF_DIV_011;
		3'b100: div_val = `ASNF_DIV_100;
		3'b101: div_val = `ASNF_DIV_101;
		default: div_val = `ASNF_DIV_111;
	endcase
end

always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		div_cnt_reg <= 9'h000;
		sub_tick <= 1'b0;
	end else if (baud_select == `ASNF_BAUD_EXT) begin
		div_cnt_reg <= 9'h000;
		sub_tick <= ext_timer_tick;
	end else if (div_cnt_reg >= div_val - 9'h001) begin
		div_cnt_reg <= 9'h000;
		sub_tick <= 1'b1;
	end else begin
		div_cnt_reg <= div_cnt_reg + 9'h001;
		sub_tick <= 1'b0;
	end
end

// transmitter
reg [2:0] tx_st_reg;
reg [3:0] tx_sub_reg;
reg [2:0] tx_bit_reg;
reg [7:0] tx_sh_reg;
reg tx_par_reg;
reg tx_stop2_reg;

always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		tx_st_reg <= TX_IDLE;
		tx_sub_reg <= 4'h0;
		tx_bit_reg <= 3'd0;
		tx_sh_reg <= 8'h00;
		tx_par_reg <= 1'b0;
		tx_stop2_reg <= 1'b0;
		tx_hold_reg <= `ASNF_HOLD_RESET;
		tx_pend_reg <= 1'b0;
		tx_armed_reg <= 1'b0;
		txempty_reg <= 1'b1;
		txdone_reg <= 1'b1;
		tx_line <= 1'b1;
		tx_irq <= 1'b0;
	end else begin
		tx_irq <= 1'b0;
		if (wr_txbuf) begin
			tx_armed_reg <= 1'b0;
			if (tx_armed_reg) begin
				tx_hold_reg <= hwdata[7:0];
				tx_pend_reg <= 1'b1;
				txempty_reg <= 1'b0;
			end
		end
		// a status read meeting a buffer write in one cycle re-arms: set wins
		if (rd_flags) begin
			tx_armed_reg <= 1'b1;
		end
		case (tx_st_reg)
			TX_IDLE: begin
				tx_line <= 1'b1;
				tx_sub_reg <= 4'h0;
				if (!tx_en) begin
					// drop what was buffered before the disable
					tx_pend_reg <= wr_txbuf & tx_armed_reg;
				end else if (sub_tick && tx_pend_reg && !wr_txbuf) begin
					tx_sh_reg <= tx_hold_reg;
					tx_par_reg <= ^tx_hold_reg ^ ~par_even;
					tx_stop2_reg <= ctrl_one_reg[`ASNF_C1_TX_STOP];
					tx_pend_reg <= 1'b0;
					txempty_reg <= 1'b1;
					tx_irq <= 1'b1;
					txdone_reg <= 1'b0;
					tx_line <= 1'b0;
					tx_st_reg <= TX_START;
				end
			end
			default: begin
				if (sub_tick) begin
					tx_sub_reg <= tx_sub_reg + 4'h1;
					if (tx_sub_reg == `ASNF_SUB_LAST) begin
						case (tx_st_reg)
							TX_START: begin
								tx_line <= tx_sh_reg[0];
								tx_bit_reg <= 3'd0;
								tx_st_reg <= TX_DATA;
							end
							TX_DATA: begin
								if (tx_bit_reg == 3'd7) begin
									tx_line <= par_ins ? tx_par_reg : 1'b1;
									tx_st_reg <= par_ins ? TX_PAR : TX_STOP;
								end else begin
									tx_line <= tx_sh_reg[1];
									tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
									tx_bit_reg <= tx_bit_reg + 3'd1;
								end
							end
							TX_PAR: begin
								tx_line <= 1'b1;
								tx_st_reg <= TX_STOP;
							end
							default: begin
								if (tx_stop2_reg) begin
									tx_stop2_reg <= 1'b0;
								end else begin
									tx_st_reg <= TX_IDLE;
									txdone_reg <= ~tx_pend_reg;
								end
							end
						endcase
					end
				end
			end
		endcase
	end
end

// receiver: two-flop synchroniser, then the filter
reg rx_meta_reg, rx_sync_reg;
wire rx_clean;
always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		rx_meta_reg <= 1'b1;
		rx_sync_reg <= 1'b1;
	end else begin
		rx_meta_reg <= rx_line;
		rx_sync_reg <= rx_meta_reg;
	end
end

asnf_rx_filter u_filter (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.line_in(rx_sync_reg),
	.filt_sel(ctrl_two_reg[`ASNF_C2_FILT_HI:`ASNF_C2_FILT_LO]),
	.line_out(rx_clean)
);

reg [2:0] rx_st_reg;
reg [3:0] rx_sub_reg;
reg [2:0] rx_bit_reg;
reg [7:0] rx_sh_reg;
reg [1:0] rx_smp_reg;
reg rx_par_bad_reg, rx_fr_bad_reg, rx_stop2_reg;
wire rx_vote = (rx_smp_reg[1] & rx_smp_reg[0]) | (rx_smp_reg[1] & rx_clean)
	| (rx_smp_reg[0] & rx_clean);
wire rx_decide = sub_tick & (rx_sub_reg == `ASNF_SUB_S9);
wire rx_last_stop = (rx_st_reg == RX_STOP) & ~rx_stop2_reg;
wire rx_done = rx_decide & rx_last_stop;
wire rx_frame_bad = rx_fr_bad_reg | ~rx_vote;
wire rx_clr = rd_rxbuf;

always @(posedge sys_clk or posedge sys_rst) begin
	if (sys_rst) begin
		rx_st_reg <= RX_IDLE;
		rx_sub_reg <= 4'h0;
		rx_bit_reg <= 3'd0;
		rx_sh_reg <= 8'h00;
		rx_smp_reg <= 2'b11;
		rx_par_bad_reg <= 1'b0;
		rx_fr_bad_reg <= 1'b0;
		rx_stop2_reg <= 1'b0;
		rx_hold_reg <= `ASNF_HOLD_RESET;
		par_fault_reg <= 1'b0;
		frame_fault_reg <= 1'b0;
		overrun_reg <= 1'b0;
		rxfull_reg <= 1'b0;
		seen_reg <= 4'h0;
		rx_irq <= 1'b0;
	end else begin
		rx_irq <= 1'b0;
		// only flags that the status read saw are cleared, so a late
		// overrun survives the buffer read
		if (rd_flags) begin
			seen_reg <= {par_fault_reg, frame_fault_reg, overrun_reg, rxfull_reg};
		end
		if (rx_clr) begin
			seen_reg <= 4'h0;
			if (seen_reg[3]) par_fault_reg <= 1'b0;
			if (seen_reg[2]) frame_fault_reg <= 1'b0;
			if (seen_reg[1]) overrun_reg <= 1'b0;
			if (seen_reg[0]) rxfull_reg <= 1'b0;
		end
		if (sub_tick) begin
			if (rx_sub_reg == `ASNF_SUB_S7) rx_smp_reg[1] <= rx_clean;
			if (rx_sub_reg == `ASNF_SUB_S8) rx_smp_reg[0] <= rx_clean;
		end
		case (rx_st_reg)
			RX_IDLE: begin
				rx_sub_reg <= 4'h0;
				// enable and overrun are only looked at between frames
				if (sub_tick && rx_en && !overrun_reg && !rx_clean) begin
					rx_sub_reg <= 4'h1;
					rx_par_bad_reg <= 1'b0;
					rx_fr_bad_reg <= 1'b0;
					rx_stop2_reg <= ctrl_two_reg[`ASNF_C2_RX_STOP];
					rx_st_reg <= RX_START;
				end
			end
			default: begin
				if (sub_tick) begin
					rx_sub_reg <= rx_sub_reg + 4'h1;
				end
				if (rx_decide) begin
					case (rx_st_reg)
						RX_START: begin
							if (rx_vote) rx_st_reg <= RX_IDLE;
						end
						RX_DATA: begin
							rx_sh_reg <= {rx_vote, rx_sh_reg[7:1]};
						end
						RX_PAR: begin
							rx_par_bad_reg <= rx_vote ^ ^rx_sh_reg ^ ~par_even;
						end
						default: begin
							if (!rx_vote) rx_fr_bad_reg <= 1'b1;
							if (rx_last_stop) rx_st_reg <= RX_IDLE;
						end
					endcase
				end
				if (sub_tick && rx_sub_reg == `ASNF_SUB_LAST) begin
					case (rx_st_reg)
						RX_START: begin
							rx_bit_reg <= 3'd0;
							rx_st_reg <= RX_DATA;
						end
						RX_DATA: begin
							rx_bit_reg <= rx_bit_reg + 3'd1;
							if (rx_bit_reg == 3'd7) begin
								rx_st_reg <= par_ins ? RX_PAR : RX_STOP;
							end
						end
						RX_PAR: begin
							rx_st_reg <= RX_STOP;
						end
						default: begin
							rx_stop2_reg <= 1'b0;
						end
					endcase
				end
			end
		endcase
		// frame end: the set lands after the clears so it wins
		if (rx_done) begin
			if (rx_frame_bad) frame_fault_reg <= 1'b1;
			if (rxfull_reg && !(rx_clr && seen_reg[0])) begin
				overrun_reg <= 1'b1;
			end else begin
				rx_hold_reg <= rx_sh_reg;
				rxfull_reg <= 1'b1;
				rx_irq <= 1'b1;
				if (par_ins && rx_par_bad_reg) par_fault_reg <= 1'b1;
			end
		end
	end
end

endmodule
`default_nettype wire

// ### asnf_props.sv
// assertions on the serial port's top-level ports.
// assumes every selectable bit lasts at least 208 clocks.
`timescale 1ns/1ps
`default_nettype none
module asnf_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic tx_line,
	input wire logic tx_irq,
	input wire logic rx_irq
);
	logic [11:0] low_run;
	logic [14:0] since_start;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// both counters saturate so a long idle never wraps into a false frame
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_run <= 12'h000;
			since_start <= 15'h7FFF;
		end else begin
			low_run <= tx_line ? 12'h000 : low_run + {11'h0, low_run != 12'hFFF};
			since_start <= tx_irq ? 15'h0000 : since_start + {14'h0, since_start != 15'h7FFF};
		end
	end
	sequence rd_at(logic [11:0] idx);
		hsel && hready && htrans[1] && !hwrite && haddr[13:2] == idx;
	endsequence
	sequence start_bit;
		tx_irq && !tx_line && $past(tx_line);
	endsequence
	txirq_pulse_a: assert property (tx_irq |=> !tx_irq)
		else $error("tx_irq wider than one cycle");
	frame_start_a: assert property (tx_irq |-> start_bit)
		else $error("tx_irq not at start bit");
	start_hold_a: assert property (start_bit |=> !tx_line [*8])
		else $error("start bit too short");
	bit_span_a: assert property ($rose(tx_line) |-> low_run >= 12'd200)
		else $error("low run shorter than a bit");
	idle_high_a: assert property (!tx_line |-> tx_irq || since_start < 15'd20000)
		else $error("tx_line low outside a frame");
	rxirq_pulse_a: assert property (rx_irq |=> !rx_irq)
		else $error("rx_irq wider than one cycle");
	flags_low_a: assert property (rd_at(12'hF98) |=> hrdata[31:8] == 24'h0 && hrdata[1:0] == 2'b00)
		else $error("flag read has stray bits");
	wo_zero_a: assert property (rd_at(12'hF99) |=> hrdata == 32'h0)
		else $error("write-only read not zero");
endmodule
bind asnf_uart asnf_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.tx_line(tx_line), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// ### asnf_peer.sv
// remote serial peer: sends frames on rx_line, decodes tx_line.
// assumes the caller gives the bit time in sys_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module asnf_peer (
	input wire logic sys_clk,
	input wire logic tx_line,
	output logic rx_line
);
	initial rx_line = 1'b1;
	task automatic drive(input logic v, input int n);
		rx_line <= v;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic send(input logic [7:0] d, input logic pb, input int nst, input logic lv,
		input int bt);
		drive(1'b0, bt);
		for (int i = 0; i < 8; i++) drive(d[i], bt);
		drive(pb, bt);
		for (int i = 1; i <= nst; i++) drive(i == nst ? lv : 1'b1, bt);
		// idle line is pulled high between frames
		rx_line <= 1'b1;
	endtask
	task automatic recv(input int bt, output logic [7:0] d, output logic p);
		do @(negedge sys_clk); while (tx_line !== 1'b0);
		repeat (bt / 2) @(negedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(negedge sys_clk);
			d[i] = tx_line;
		end
		repeat (bt) @(negedge sys_clk);
		p = tx_line;
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the serial port over AHB-Lite.
// assumes zero-wait-state slave and a peer model on the serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "asnf_consts.vh"
module tb_top;
	localparam logic [11:0] C1 = `ASNF_IDX_CTRL_ONE;
	localparam logic [11:0] C2 = `ASNF_IDX_CTRL_TWO;
	localparam logic [11:0] BF = `ASNF_IDX_TX_HOLD;
	logic sys_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, ext_timer_tick = 0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [3:0] tk = 4'h0;
	logic [7:0] rb;
	logic rp;
	wire hready, hresp, tx_line, tx_irq, rx_irq, rx_line;
	wire [31:0] hrdata;
	int failures = 0, total_checks = 0, lowcnt = 0;
	asnf_uart dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ext_timer_tick(ext_timer_tick),
		.rx_line(rx_line), .tx_line(tx_line), .tx_irq(tx_irq), .rx_irq(rx_irq));
	asnf_peer peer (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(rx_line));
	always #5 sys_clk = ~sys_clk;
	// timer tick every 16 clocks makes a 256-clock bit
	always @(posedge sys_clk) begin
		tk <= tk + 4'h1;
		ext_timer_tick <= (tk == 4'hF);
		lowcnt <= lowcnt + (tx_line === 1'b0);
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		// start on a rising edge even when called after a falling-edge wait
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {18'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
		check(hresp, 32'h0);
	endtask
	task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
		logic [31:0] v;
		bus(1'b0, idx, 8'h00, v);
		check(v, {24'h0, exp});
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		logic [31:0] v;
		bus(1'b1, idx, d, v);
	endtask
	task automatic wait_irq(input logic rx, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while ((rx ? rx_irq : tx_irq) !== 1'b1 && n < lim);
		check(n < lim, 1);
	endtask
	task automatic t_idle;
		int lows;
		lows = 0;
		wr(C1, 8'h80);
		wr(BF, 8'h55);
		repeat (3000) begin
			@(negedge sys_clk);
			lows += (tx_line !== 1'b1);
		end
		check(lows, 0);
		rd(C1, 8'h0C);
		rd(BF, 8'h00);
		rd(C2, 8'h00);
	endtask
	task automatic t_tx(input logic [7:0] cfg, input int bt, input logic [7:0] b);
		int nb, l0;
		time t0;
		logic p;
		nb = 10 + cfg[`ASNF_C1_PAR_INS] + cfg[`ASNF_C1_TX_STOP];
		p = cfg[`ASNF_C1_EVEN] ? ^b : ~^b;
		wr(C1, 8'h00);
		wr(C1, cfg);
		fork
			peer.recv(bt, rb, rp);
			begin
				rd(C1, 8'h0C);
				wr(BF, b);
				wait_irq(1'b0, 120);
				t0 = $time;
				rd(C1, 8'h04);
				wr(BF, ~b);
				rd(C1, 8'h00);
				wait_irq(1'b0, nb * bt + 200);
				check(($time - t0) / 10 >= nb * bt && ($time - t0) / 10 <= nb * bt + bt / 16, 1);
				l0 = lowcnt;
				wr(C1, cfg & 8'h7F);
				repeat (nb * bt + bt) @(negedge sys_clk);
				check(lowcnt - l0, (1 + $countones(b) + (cfg[3] && !p)) * bt);
				rd(C1, 8'h0C);
			end
		join
		check(rb, b);
		if (cfg[`ASNF_C1_PAR_INS])
			check(rp, p);
	endtask
	task automatic t_rx;
		logic [31:0] v;
		wr(C1, 8'h00);
		wr(C1, 8'h48);
		wr(C2, 8'h06);
		peer.drive(1'b0, 100);
		peer.drive(1'b1, 800);
		rd(C1, 8'h0C);
		peer.send(8'hC3, 1'b1, 1, 1'b1, 208);
		wait_irq(1'b1, 300);
		rd(C1, 8'h1C);
		peer.send(8'h5A, 1'b1, 1, 1'b1, 208);
		repeat (300) @(negedge sys_clk);
		rd(C1, 8'h3C);
		rd(BF, 8'hC3);
		rd(C1, 8'h0C);
		peer.send(8'h0F, 1'b0, 1, 1'b1, 208);
		wait_irq(1'b1, 300);
		rd(C1, 8'h9C);
		rd(BF, 8'h0F);
		rd(C1, 8'h0C);
		wr(C2, 8'h07);
		peer.send(8'hA0, 1'b1, 2, 1'b0, 208);
		repeat (600) @(negedge sys_clk);
		bus(1'b0, C1, 8'h00, v);
		check(v & 32'h40, 32'h40);
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_idle();
		t_tx(8'h80, 208, 8'hA5);
		t_tx(8'h81, 416, 8'h5C);
		t_tx(8'hBE, 256, 8'h3C);
		t_tx(8'h8F, 1536, 8'h96);
		t_rx();
		report_and_stop();
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
